// File: core/stc_pkg.sv
// package: register map, field positions and state types of the scan test control block
package stc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIST = 8'h04;
  localparam logic [7:0] OFF_CNTA = 8'h08;
  localparam logic [7:0] OFF_CNTB = 8'h0C;
  localparam logic [7:0] OFF_REPS = 8'h10;
  localparam logic [7:0] OFF_STIM = 8'h14;
  localparam logic [7:0] OFF_RESP = 8'h18;
  // ---------------------------------------------------------------
  // test_control field positions
  // ---------------------------------------------------------------
  localparam int B_ETM = 0;
  localparam int B_AUTO = 1;
  localparam int B_SHIFT = 2;
  localparam int B_CONT = 3;
  localparam int B_ACT = 4;
  localparam int B_RSEL = 9;
  localparam int B_QSEL = 10;
  localparam int B_PCONN = 11;
  localparam int B_IMB = 12;
  localparam int B_COMP = 13;
  localparam int B_ARMED = 14;
  localparam int B_BUSY = 15;
  // ---------------------------------------------------------------
  // test_distributed_config field positions
  // ---------------------------------------------------------------
  localparam int B_BCFG = 0;
  localparam int B_BUP = 1;
  localparam int B_ACFG = 4;
  localparam int B_AUP = 5;
  localparam int B_WAIT = 8;
  // ---------------------------------------------------------------
  // timing, answers, reset values
  // ---------------------------------------------------------------
  localparam int WAIT_STEP = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] DIST_RST = 16'h0000;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SHIFT, SEQ_WAIT} stc_seq_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } stc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } stc_axi_rsp_t;

  typedef struct packed {
    logic stim_line;
    logic sce_a;
    logic sce_b;
    logic act_line;
    logic quot_pin;
    logic test_mode;
    logic proc_conn;
    logic self_reset;
  } stc_scan_out_t;

  typedef struct packed {
    logic tme1;
    logic tme2;
    logic irq1;
    logic irq2;
    stc_axi_rsp_t rsp;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } stc_io_t;

  typedef struct packed {
    logic etm_done;
    logic auto_go;
    logic shift_go;
    logic cont;
    logic rsel;
    logic qsel;
    logic pconn;
    logic imb;
    logic busy;
    logic [2:0] wait_pre;
    logic a_cfg;
    logic b_cfg;
    logic [18:0] stimulus_shift_reg;
    logic [18:0] response_shift_reg;
    logic [7:0] cnt_a_ld;
    logic [7:0] cnt_b_ld;
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic [15:0] reps;
    logic [4:0] wait_cnt;
    stc_seq_t seq;
    stc_scan_out_t so;
  } stc_core_t;

  typedef struct packed {
    stc_io_t io;
    stc_core_t c;
  } stc_state_t;

  localparam stc_core_t CORE_RST = '0;
  localparam stc_state_t STATE_RST = '0;
endpackage : stc_pkg

// File: core/stc_ctrl.sv
// scan test control: entry gating, control/config registers, shift and automatic sequencing
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module stc_ctrl #(
  parameter logic [18:0] GOOD_SIG = 19'h00000,
  parameter logic [18:0] A_TAPS = 19'h40027,
  parameter logic [18:0] B_TAPS = 19'h40027
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire stc_pkg::stc_axi_req_t AXI_REQ,
  output var stc_pkg::stc_axi_rsp_t AXI_RSP,
  input wire logic TEST_MODE_ENABLE_PIN_N,
  input wire logic EXT_IRQ_PIN,
  input wire logic RESPONSE_SCAN_LINE,
  input wire logic FREEZE_STATUS,
  output var stc_pkg::stc_scan_out_t SCAN_OUT
);
  import stc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  stc_state_t q_r;
  stc_state_t q_nxt;
  logic armed;
  logic srst;
  logic wr;
  logic rd;
  logic sw_shift;
  logic b_in;
  logic [15:0] wmask;
  logic [15:0] wd;
  logic [15:0] ctl_rd;
  logic [15:0] dst_rd;
  logic [15:0] cw;
  logic [15:0] dw;
  logic [15:0] reps_dec;

  assign AXI_RSP = q_r.io.rsp;
  assign SCAN_OUT = q_r.c.so;

  // ---------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------
  always_comb begin
    armed = !q_r.io.tme2;
    ctl_rd = '0;
    ctl_rd[B_ETM] = q_r.c.so.test_mode;
    ctl_rd[B_AUTO] = q_r.c.auto_go;
    ctl_rd[B_SHIFT] = q_r.c.shift_go;
    ctl_rd[B_CONT] = q_r.c.cont;
    ctl_rd[B_RSEL] = q_r.c.rsel;
    ctl_rd[B_QSEL] = q_r.c.qsel & q_r.c.so.test_mode;
    ctl_rd[B_PCONN] = q_r.c.pconn;
    ctl_rd[B_IMB] = q_r.c.imb & q_r.c.so.test_mode;
    ctl_rd[B_COMP] = (q_r.c.response_shift_reg == GOOD_SIG);
    ctl_rd[B_ARMED] = armed;
    ctl_rd[B_BUSY] = q_r.c.busy;
    dst_rd = DIST_RST;
    dst_rd[B_WAIT+:3] = q_r.c.wait_pre;
    dst_rd[B_AUP+:3] = q_r.c.stimulus_shift_reg[18:16];
    dst_rd[B_ACFG] = q_r.c.a_cfg;
    dst_rd[B_BUP+:3] = q_r.c.response_shift_reg[18:16];
    dst_rd[B_BCFG] = q_r.c.b_cfg;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    sw_shift = 1'b0;
    reps_dec = q_r.c.reps - 16'h0001;
    q_nxt.io.tme1 = TEST_MODE_ENABLE_PIN_N;
    q_nxt.io.tme2 = q_r.io.tme1;
    q_nxt.io.irq1 = EXT_IRQ_PIN;
    q_nxt.io.irq2 = q_r.io.irq1;
    q_nxt.c.so.act_line = 1'b0;
    q_nxt.c.so.self_reset = 1'b0;
    // write channel capture, address and data in either order
    if (AXI_REQ.awvalid && q_r.io.rsp.awready) begin
      q_nxt.io.aw_held = 1'b1;
      q_nxt.io.awaddr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && q_r.io.rsp.wready) begin
      q_nxt.io.w_held = 1'b1;
      q_nxt.io.wdata = AXI_REQ.wdata;
      q_nxt.io.wstrb = AXI_REQ.wstrb;
    end
    if (q_r.io.rsp.bvalid && AXI_REQ.bready) begin
      q_nxt.io.rsp.bvalid = 1'b0;
    end
    wr = q_r.io.aw_held && q_r.io.w_held && !q_r.io.rsp.bvalid;
    wmask = {{8{q_r.io.wstrb[1]}}, {8{q_r.io.wstrb[0]}}};
    wd = q_r.io.wdata[15:0];
    cw = (ctl_rd & ~wmask) | (wd & wmask);
    dw = (dst_rd & ~wmask) | (wd & wmask);
    if (wr) begin
      q_nxt.io.aw_held = 1'b0;
      q_nxt.io.w_held = 1'b0;
      q_nxt.io.rsp.bvalid = 1'b1;
      q_nxt.io.rsp.bresp = RESP_OKAY;
      case (q_r.io.awaddr)
        OFF_CTRL: begin
          if (wmask[B_ETM] && !q_r.c.etm_done) begin
            q_nxt.c.etm_done = 1'b1;
            q_nxt.c.so.test_mode = cw[B_ETM] & armed;
          end
          if (wmask[0]) begin
            q_nxt.c.auto_go = cw[B_AUTO];
            sw_shift = cw[B_SHIFT];
            q_nxt.c.shift_go = q_r.c.shift_go | cw[B_SHIFT];
            q_nxt.c.cont = cw[B_CONT];
            q_nxt.c.so.act_line = cw[B_ACT];
          end
          if (wmask[8] && q_r.c.so.test_mode) begin
            q_nxt.c.rsel = cw[B_RSEL];
            q_nxt.c.qsel = cw[B_QSEL];
            q_nxt.c.pconn = cw[B_PCONN];
            q_nxt.c.imb = cw[B_IMB];
          end
        end
        OFF_DIST: begin
          q_nxt.c.wait_pre = dw[B_WAIT+:3];
          q_nxt.c.stimulus_shift_reg[18:16] = dw[B_AUP+:3];
          q_nxt.c.a_cfg = dw[B_ACFG];
          q_nxt.c.response_shift_reg[18:16] = dw[B_BUP+:3];
          q_nxt.c.b_cfg = dw[B_BCFG];
        end
        OFF_CNTA: begin
          if (wmask[0]) begin
            q_nxt.c.cnt_a_ld = wd[7:0];
          end
        end
        OFF_CNTB: begin
          if (wmask[0]) begin
            q_nxt.c.cnt_b_ld = wd[7:0];
          end
        end
        OFF_REPS: q_nxt.c.reps = (q_r.c.reps & ~wmask) | (wd & wmask);
        OFF_STIM: q_nxt.c.stimulus_shift_reg[15:0] = (q_r.c.stimulus_shift_reg[15:0] & ~wmask) | (wd & wmask);
        OFF_RESP: q_nxt.c.response_shift_reg[15:0] = (q_r.c.response_shift_reg[15:0] & ~wmask) | (wd & wmask);
        default: q_nxt.io.rsp.bresp = RESP_SLVERR;
      endcase
    end
    // read channel, answer one cycle after the address is taken
    rd = AXI_REQ.arvalid && q_r.io.rsp.arready;
    if (q_r.io.rsp.rvalid && AXI_REQ.rready) begin
      q_nxt.io.rsp.rvalid = 1'b0;
    end
    if (rd) begin
      q_nxt.io.rsp.rvalid = 1'b1;
      q_nxt.io.rsp.rresp = RESP_OKAY;
      q_nxt.io.rsp.rdata = '0;
      case (AXI_REQ.araddr)
        OFF_CTRL: q_nxt.io.rsp.rdata[15:0] = ctl_rd;
        OFF_DIST: q_nxt.io.rsp.rdata[15:0] = dst_rd;
        OFF_CNTA: q_nxt.io.rsp.rdata[7:0] = q_r.c.cnt_a_ld;
        OFF_CNTB: q_nxt.io.rsp.rdata[7:0] = q_r.c.cnt_b_ld;
        OFF_REPS: q_nxt.io.rsp.rdata[15:0] = q_r.c.reps;
        OFF_STIM: q_nxt.io.rsp.rdata[15:0] = q_r.c.stimulus_shift_reg[15:0];
        OFF_RESP: q_nxt.io.rsp.rdata[15:0] = q_r.c.response_shift_reg[15:0];
        default: q_nxt.io.rsp.rresp = RESP_SLVERR;
      endcase
    end

    // -------------------------------------------------------------
    // shifting: stimulus out, response in
    // -------------------------------------------------------------
    b_in = q_r.c.imb ? (q_r.c.rsel ? q_r.io.irq2 : RESPONSE_SCAN_LINE) : q_r.c.stimulus_shift_reg[0];
    if (q_r.c.seq == SEQ_SHIFT && q_r.c.cnt_a != 8'h00) begin
      q_nxt.c.cnt_a = q_r.c.cnt_a - 8'h01;
      if (q_r.c.a_cfg) begin
        q_nxt.c.stimulus_shift_reg = {^(q_r.c.stimulus_shift_reg & A_TAPS), q_r.c.stimulus_shift_reg[18:1]};
      end else begin
        q_nxt.c.stimulus_shift_reg[15:0] = {1'b0, q_r.c.stimulus_shift_reg[15:1]};
      end
    end
    if ((q_r.c.seq == SEQ_SHIFT && q_r.c.cnt_b != 8'h00) || q_r.c.cont) begin
      if (q_r.c.seq == SEQ_SHIFT && q_r.c.cnt_b != 8'h00) begin
        q_nxt.c.cnt_b = q_r.c.cnt_b - 8'h01;
      end
      if (q_r.c.b_cfg) begin
        q_nxt.c.response_shift_reg = {b_in ^ (^(q_r.c.response_shift_reg & B_TAPS)), q_r.c.response_shift_reg[18:1]};
      end else begin
        q_nxt.c.response_shift_reg[15:0] = {b_in, q_r.c.response_shift_reg[15:1]};
      end
    end

    // -------------------------------------------------------------
    // sequencing
    // -------------------------------------------------------------
    case (q_r.c.seq)
      SEQ_IDLE: begin
        if (q_nxt.c.shift_go || q_nxt.c.auto_go) begin
          q_nxt.c.seq = SEQ_SHIFT;
          q_nxt.c.cnt_a = q_r.c.cnt_a_ld;
          q_nxt.c.cnt_b = q_r.c.cnt_b_ld;
        end
      end
      SEQ_SHIFT: begin
        if (q_r.c.cnt_a == 8'h00 && q_r.c.cnt_b == 8'h00) begin
          q_nxt.c.shift_go = sw_shift;
          q_nxt.c.seq = SEQ_IDLE;
          if (q_r.c.auto_go) begin
            // a zero reps count is treated as one vector, never wraps
            q_nxt.c.reps = (q_r.c.reps == 16'h0000) ? 16'h0000 : reps_dec;
            if (q_r.c.reps > 16'h0001) begin
              q_nxt.c.so.act_line = 1'b1;
              q_nxt.c.wait_cnt = 5'((32'(q_r.c.wait_pre) + 1) * WAIT_STEP);
              q_nxt.c.seq = SEQ_WAIT;
            end else begin
              q_nxt.c.auto_go = 1'b0;
            end
          end
        end
      end
      SEQ_WAIT: begin
        if (q_r.c.wait_cnt <= 5'h01) begin
          q_nxt.c.seq = SEQ_SHIFT;
          q_nxt.c.cnt_a = q_r.c.cnt_a_ld;
          q_nxt.c.cnt_b = q_r.c.cnt_b_ld;
        end else begin
          q_nxt.c.wait_cnt = q_r.c.wait_cnt - 5'h01;
        end
        // software dropping the auto bit ends the run at once, without waiting out the count
        if (!q_nxt.c.auto_go) begin
          q_nxt.c.seq = SEQ_IDLE;
        end
      end
      default: q_nxt.c.seq = SEQ_IDLE;
    endcase

    // -------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------
    q_nxt.c.busy = (q_nxt.c.seq != SEQ_IDLE) || q_nxt.c.cont || q_nxt.c.auto_go;
    q_nxt.c.so.sce_a = (q_nxt.c.seq == SEQ_SHIFT) && (q_nxt.c.cnt_a != 8'h00);
    q_nxt.c.so.sce_b = ((q_nxt.c.seq == SEQ_SHIFT) && (q_nxt.c.cnt_b != 8'h00)) || q_nxt.c.cont;
    q_nxt.c.so.stim_line = q_nxt.c.imb & q_nxt.c.stimulus_shift_reg[0];
    q_nxt.c.so.quot_pin = (q_nxt.c.so.test_mode && q_nxt.c.qsel) ? q_nxt.c.response_shift_reg[0] : FREEZE_STATUS;
    q_nxt.c.so.proc_conn = q_nxt.c.pconn;
    // the bus side survives the self reset so a pending answer is not lost
    srst = q_r.c.so.test_mode && q_r.io.tme2;
    if (srst) begin
      q_nxt.c = CORE_RST;
      q_nxt.c.so.self_reset = 1'b1;
      q_nxt.c.so.quot_pin = FREEZE_STATUS;
    end
    q_nxt.io.rsp.awready = !q_nxt.io.aw_held && !q_nxt.io.rsp.bvalid;
    q_nxt.io.rsp.wready = !q_nxt.io.w_held && !q_nxt.io.rsp.bvalid;
    q_nxt.io.rsp.arready = !q_nxt.io.rsp.rvalid;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q_r <= STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  property p_enter_gate;
    $rose(q_r.c.so.test_mode) |-> !$past(q_r.io.tme2);
  endproperty
  a_enter_gate: assert property (p_enter_gate) else $error("test mode entered without pin");

  property p_write_once;
    q_r.c.etm_done && !srst |=> $stable(q_r.c.so.test_mode) || $rose(q_r.c.so.self_reset);
  endproperty
  a_write_once: assert property (p_write_once) else $error("enter bit changed twice");

  property p_self_reset;
    q_r.c.so.test_mode && q_r.io.tme2 |=> !q_r.c.so.test_mode && q_r.c.so.self_reset;
  endproperty
  a_self_reset: assert property (p_self_reset) else $error("no self reset on pin rise");

  property p_shift_done;
    q_r.c.seq == SEQ_SHIFT && q_r.c.cnt_a == 8'h00 && q_r.c.cnt_b == 8'h00 && !wr
      |=> !q_r.c.shift_go && !q_r.c.so.sce_a;
  endproperty
  a_shift_done: assert property (p_shift_done) else $error("shift bit not cleared");

  property p_act_pulse;
    q_r.c.so.act_line |=> !q_r.c.so.act_line;
  endproperty
  a_act_pulse: assert property (p_act_pulse) else $error("activate longer than one cycle");

  property p_wait_load;
    q_r.c.seq == SEQ_WAIT && $past(q_r.c.seq) == SEQ_SHIFT
      |-> q_r.c.so.act_line
      && q_r.c.wait_cnt == {$past(q_r.c.wait_pre) + 3'h1 == 3'h0, $past(q_r.c.wait_pre) + 3'h1, 1'b0};
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("wait count wrong");

  property p_wait_hold;
    q_r.c.seq == SEQ_WAIT && q_r.c.wait_cnt > 5'h01 && q_nxt.c.auto_go |=> q_r.c.seq == SEQ_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("shift before wait over");

  property p_auto_step;
    q_r.c.seq == SEQ_SHIFT && q_r.c.cnt_a == 8'h00 && q_r.c.cnt_b == 8'h00 && q_r.c.auto_go
      && q_r.c.reps > 16'h0001 && !wr && !srst
      |=> q_r.c.so.act_line && q_r.c.reps == $past(q_r.c.reps) - 16'h0001;
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("auto step missing");

  property p_busy;
    q_r.c.busy == (q_r.c.seq != SEQ_IDLE || q_r.c.cont || q_r.c.auto_go);
  endproperty
  a_busy: assert property (p_busy) else $error("busy mismatch");

  property p_freeze;
    !q_nxt.c.so.test_mode |=> q_r.c.so.quot_pin == $past(FREEZE_STATUS);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze pin not routed");

  c_enter: cover property ($rose(q_r.c.so.test_mode));
  c_auto_done: cover property ($fell(q_r.c.auto_go) && q_r.c.seq == SEQ_IDLE);
  c_wait: cover property (q_r.c.seq == SEQ_WAIT ##1 q_r.c.seq == SEQ_SHIFT);
  c_cont: cover property (q_r.c.cont && q_r.c.so.sce_b);
endmodule : stc_ctrl

`default_nettype wire

// File: test/stc_mut_model.sv
// partner model: scan chain of the module under test behind the scan lines
`timescale 1ns/1ps
`default_nettype none
module stc_mut_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire stc_pkg::stc_scan_out_t so,
  output logic resp_line
);
  import stc_pkg::*;
  logic [15:0] chain;
  logic last;
  // ---------------------------------------------------------------
  // chain: stimulus in on enable a, response out on enable b
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain <= 16'h0000;
      last <= 1'b0;
    end else begin
      if (so.act_line) begin
        chain <= ~chain;
      end else if (so.sce_a || so.sce_b) begin
        chain <= {so.sce_a ? so.stim_line : chain[0], chain[15:1]};
      end
      if (so.sce_b) begin
        last <= chain[0];
      end
    end
  end
  // released line shows the inverse of its last bit, never a stale copy
  assign resp_line = so.sce_b ? chain[0] : ~last;
endmodule : stc_mut_model
`default_nettype wire

// File: test/tb_scan_test_control_config.sv
// testbench: register table, entry gating, shift, automatic and continuous runs
`timescale 1ns/1ps
`default_nettype none
module tb_scan_test_control_config;
  import stc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] r;} stc_row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_n = 1'b1;
  logic irq = 1'b0;
  logic freeze = 1'b1;
  logic resp_line;
  stc_axi_req_t req = '0;
  stc_axi_rsp_t rsp;
  stc_scan_out_t so;
  int miscompares = 0;
  int n_tests = 0;
  int n_sa = 0;
  int n_sb = 0;
  int n_act = 0;
  int n_srst = 0;
  int n_one = 0;
  int cyc = 0;
  int t_act = -1;
  int min_gap = 999;
  logic sa_q = 1'b0;
  logic [15:0] rv;
  logic [1:0] rr;
  stc_row_t rows [7] = '{
    '{OFF_DIST, 16'hFFFF, 16'h07FF, RESP_OKAY},
    '{OFF_DIST, 16'h0000, 16'h0000, RESP_OKAY},
    '{OFF_CNTA, 16'h1234, 16'h0034, RESP_OKAY},
    '{OFF_REPS, 16'hBEEF, 16'hBEEF, RESP_OKAY},
    '{OFF_STIM, 16'hA5A5, 16'hA5A5, RESP_OKAY},
    '{OFF_CTRL, 16'h1E00, 16'h2000, RESP_OKAY},
    '{8'h1C, 16'hFFFF, 16'h0000, RESP_SLVERR}
  };

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  stc_ctrl dut (
    .SYS_CLK(sys_clk),
    .RESET_N(reset_n),
    .AXI_REQ(req),
    .AXI_RSP(rsp),
    .TEST_MODE_ENABLE_PIN_N(pin_n),
    .EXT_IRQ_PIN(irq),
    .RESPONSE_SCAN_LINE(resp_line),
    .FREEZE_STATUS(freeze),
    .SCAN_OUT(so)
  );

  stc_mut_model mut (.clk(sys_clk), .rst_n(reset_n), .so(so), .resp_line(resp_line));

  // ---------------------------------------------------------------
  // monitors on the scan side
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sa_q <= so.sce_a;
    if (so.sce_a) n_sa <= n_sa + 1;
    if (so.sce_b) n_sb <= n_sb + 1;
    if (so.self_reset) n_srst <= n_srst + 1;
    if (so.sce_a && so.stim_line) n_one <= n_one + 1;
    if (so.act_line) begin
      n_act <= n_act + 1;
      t_act <= cyc;
    end
    if (so.sce_a && !sa_q && t_act >= 0 && cyc - t_act < min_gap) min_gap <= cyc - t_act;
  end

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      // ready seen at the falling edge is what the next rising edge samples
      @(negedge sys_clk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge sys_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge sys_clk);
      ar = req.arvalid && rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata[15:0];
      r = rsp.rresp;
      @(posedge sys_clk);
      if (ar) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    rd(a, rv, rr);
    chk(rv, e);
  endtask : rdchk

  task automatic wait_idle;
    do rd(OFF_CTRL, rv, rr); while (rv[B_BUSY] !== 1'b0);
  endtask : wait_idle

  task automatic clr;
    @(negedge sys_clk);
    n_sa = 0;
    n_sb = 0;
    n_act = 0;
    n_srst = 0;
    n_one = 0;
    t_act = -1;
    min_gap = 999;
  endtask : clr

  task automatic do_reset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset;
    rdchk(OFF_DIST, DIST_RST);
    // control row writes the enter bit as zero first, so the later entry attempt must fail
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rr);
      chk({14'h0000, rr}, {14'h0000, rows[i].r});
      rdchk(rows[i].a, rows[i].e);
    end
    pin_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdchk(OFF_CTRL, 16'h6000);
    wr(OFF_CTRL, 16'h0001, rr);
    @(negedge sys_clk);
    chk({15'h0000, so.test_mode}, 16'h0000);
    do_reset;
    wr(OFF_CTRL, 16'h0001, rr);
    @(negedge sys_clk);
    chk({15'h0000, so.test_mode}, 16'h0001);
    rdchk(OFF_CTRL, 16'h6001);
    wr(OFF_STIM, 16'h00A5, rr);
    wr(OFF_CNTA, 16'h0008, rr);
    wr(OFF_CNTB, 16'h0008, rr);
    wr(OFF_CTRL, 16'h0005, rr);
    wait_idle;
    rdchk(OFF_RESP, 16'hA500);
    rdchk(OFF_STIM, 16'h0000);
    @(negedge sys_clk);
    chk({15'h0000, so.quot_pin}, 16'h0001);
    @(posedge sys_clk);
    freeze <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({15'h0000, so.quot_pin}, 16'h0000);
    @(posedge sys_clk);
    freeze <= 1'b1;
    wr(OFF_CTRL, 16'h0401, rr);
    repeat (2) @(negedge sys_clk);
    chk({15'h0000, so.quot_pin}, 16'h0000);
    @(posedge sys_clk);
    irq <= 1'b1;
    wr(OFF_CNTA, 16'h0000, rr);
    wr(OFF_CNTB, 16'h0010, rr);
    wr(OFF_CTRL, 16'h1201, rr);
    wr(OFF_CTRL, 16'h1205, rr);
    wait_idle;
    rdchk(OFF_RESP, 16'hFFFF);
    wr(OFF_CTRL, 16'h1801, rr);
    @(negedge sys_clk);
    chk({15'h0000, so.proc_conn}, 16'h0001);
    wr(OFF_STIM, 16'h00F0, rr);
    wr(OFF_CNTA, 16'h00C8, rr);
    wr(OFF_CNTB, 16'h0003, rr);
    clr;
    wr(OFF_CTRL, 16'h1805, rr);
    wr(OFF_CTRL, 16'h1801, rr);
    rd(OFF_CTRL, rv, rr);
    chk(rv & 16'h8004, 16'h8004);
    wait_idle;
    chk(n_sa[15:0], 16'd200);
    chk(n_sb[15:0], 16'd3);
    chk(n_one[15:0], 16'd4);
    wr(OFF_DIST, 16'h00FF, rr);
    wr(OFF_STIM, 16'h0000, rr);
    wr(OFF_CNTA, 16'h0003, rr);
    wr(OFF_CNTB, 16'h0003, rr);
    wr(OFF_CTRL, 16'h1805, rr);
    wait_idle;
    rdchk(OFF_STIM, 16'hE000);
    rd(OFF_RESP, rv, rr);
    chk(rv & 16'hE000, 16'hE000);
    wr(OFF_DIST, 16'h0300, rr);
    wr(OFF_CNTA, 16'h0002, rr);
    wr(OFF_CNTB, 16'h0002, rr);
    wr(OFF_REPS, 16'h0003, rr);
    clr;
    wr(OFF_CTRL, 16'h1807, rr);
    wait_idle;
    chk(rv & 16'h800E, 16'h0000);
    chk(n_act[15:0], 16'd2);
    chk(n_sa[15:0], 16'd6);
    chk({15'h0000, min_gap == 8}, 16'h0001);
    clr;
    wr(OFF_CTRL, 16'h1811, rr);
    @(negedge sys_clk);
    chk(n_act[15:0], 16'd1);
    rd(OFF_CTRL, rv, rr);
    chk(rv & 16'h0010, 16'h0000);
    wr(OFF_REPS, 16'h0001, rr);
    wr(OFF_CNTA, 16'h0000, rr);
    wr(OFF_CNTB, 16'h0000, rr);
    wr(OFF_CTRL, 16'h180F, rr);
    repeat (20) @(negedge sys_clk);
    rd(OFF_CTRL, rv, rr);
    chk(rv & 16'h8008, 16'h8008);
    wr(OFF_CTRL, 16'h1801, rr);
    wait_idle;
    chk(rv & 16'h800E, 16'h0000);
    pin_n <= 1'b1;
    clr;
    repeat (6) @(negedge sys_clk);
    chk(n_srst[15:0], 16'd1);
    chk({15'h0000, so.test_mode}, 16'h0000);
    rdchk(OFF_CTRL, 16'h2000);
    end_sim;
  end

  // a hung handshake or busy poll ends the run here
  initial begin
    #2000000;
    miscompares++;
    end_sim;
  end
endmodule : tb_scan_test_control_config
`default_nettype wire
